// File: rtl/cis_ctl_in_status.sv
`timescale 1ns/1ns
// How it works
// - successful setup stage sets the in data toggle to one
// - each successful in data stage inverts the in data toggle
// - toggle zero sends DATA0, toggle one sends DATA1
// - detecting the status stage sets status stage seen
// - start of next setup stage clears status stage seen
// - valid in token with stall request set is answered with STALL
// - in transaction ending in STALL sets the stalled bit
// - valid in token with no armed fifo packet is answered with NAK
// - in transaction ending in NAK sets the not acknowledged bit
// - timeout, stuffing, crc, forced or other error sets error bit
// - stalled, nak and error bits follow latest valid in transaction
// - data sent and host ACK sets the acknowledged bit
// - acknowledged becoming set also sets the transmit interrupt bit
// - start of next setup stage clears the acknowledged bit
// - only acknowledged writable; bits 6,5 reserved; reset clears all
// - software stall request makes next valid in token get STALL
// - acknowledged becoming set clears the fifo armed bit
module cis_ctl_in_status #(
  parameter logic [3:0] CTL_ENDP = 4'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cis_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cis_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cis_pkg::cis_link_ev_t link_ev,
  input wire cis_pkg::cis_token_t token,
  input wire logic fifo_arm_set,
  output cis_pkg::cis_hs_t hs_answer,
  output logic data_pid_one,
  output logic tx_intr
);
  import cis_pkg::*;

  logic toggle_q;
  logic stage_q;
  logic stalled_q;
  logic naked_q;
  logic error_q;
  logic acked_q;
  logic stall_req_q;
  logic armed_q;
  logic intr_q;
  logic in_busy_q;
  logic [7:0] status_w;
  logic [7:0] ctrl_w;
  logic [7:0] intr_w;
  logic token_ok;
  logic in_end;
  logic ack_event;
  logic data_ok;
  logic aw_q;
  logic w_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : hit

  // link layer has already matched the device address
  assign token_ok = link_ev.in_token && token.token_crc_ok &&
                    (token.endp == CTL_ENDP);
  // in transaction ends on handshake out, data sent, or error
  assign in_end = in_busy_q && (link_ev.tx_done || link_ev.tx_error);
  assign data_ok = link_ev.tx_done && link_ev.host_ack &&
                   (hs_answer == HS_DATA);
  assign ack_event = in_end && data_ok && !link_ev.tx_error;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_busy_q <= 1'b0;
      hs_answer <= HS_NONE;
    end else if (token_ok) begin
      in_busy_q <= 1'b1;
      if (stall_req_q) begin
        hs_answer <= HS_STALL;
      end else if (!armed_q) begin
        hs_answer <= HS_NAK;
      end else begin
        hs_answer <= HS_DATA;
      end
    end else if (in_end) begin
      in_busy_q <= 1'b0;
      hs_answer <= HS_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_pid_one <= 1'b0;
    end else begin
      data_pid_one <= toggle_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_q <= 1'b0;
    end else if (link_ev.setup_done) begin
      toggle_q <= 1'b1;
    end else if (ack_event) begin
      toggle_q <= ~toggle_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_q <= 1'b0;
    end else if (link_ev.status_stage) begin
      stage_q <= 1'b1;
    end else if (link_ev.setup_begin) begin
      stage_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stalled_q <= 1'b0;
      naked_q <= 1'b0;
      error_q <= 1'b0;
    end else if (in_end) begin
      // each outcome overwrites the last one
      stalled_q <= !link_ev.tx_error && hs_answer == HS_STALL;
      naked_q <= !link_ev.tx_error && hs_answer == HS_NAK;
      error_q <= link_ev.tx_error ||
                 (hs_answer == HS_DATA && !link_ev.host_ack);
    end
  end

  // set beats the software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acked_q <= 1'b0;
    end else if (ack_event) begin
      acked_q <= 1'b1;
    end else if (link_ev.setup_begin) begin
      acked_q <= 1'b0;
    end else if (wr_fire && hit(awaddr_q, OFF_STATUS) && wstrb_q[0] &&
                 wdata_q[BIT_ACKED]) begin
      acked_q <= 1'b0;
    end
  end

  // write-one-to-clear, same as the status acknowledge bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intr_q <= 1'b0;
    end else if (ack_event) begin
      intr_q <= 1'b1;
    end else if ((wr_fire && hit(awaddr_q, OFF_STATUS) && wstrb_q[0] &&
                  wdata_q[BIT_ACKED]) ||
                 (wr_fire && hit(awaddr_q, OFF_INTR) && wstrb_q[0] &&
                  wdata_q[BIT_TX_INTR])) begin
      intr_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_intr <= 1'b0;
    end else begin
      tx_intr <= intr_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_req_q <= 1'b0;
    end else if (link_ev.setup_done) begin
      stall_req_q <= 1'b0;
    end else if (wr_fire && hit(awaddr_q, OFF_CTRL) && wstrb_q[0]) begin
      stall_req_q <= wdata_q[BIT_STALL_REQ];
    end
  end

  // hardware clear wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (ack_event || link_ev.setup_done) begin
      armed_q <= 1'b0;
    end else if (fifo_arm_set) begin
      armed_q <= 1'b1;
    end else if (wr_fire && hit(awaddr_q, OFF_CTRL) && wstrb_q[0]) begin
      armed_q <= wdata_q[BIT_FIFO_ARMED];
    end
  end

  always_comb begin
    status_w = STATUS_RESET;
    status_w[BIT_TOGGLE] = toggle_q;
    status_w[BIT_STAGE] = stage_q;
    status_w[BIT_STALLED] = stalled_q;
    status_w[BIT_NAKED] = naked_q;
    status_w[BIT_ERROR] = error_q;
    status_w[BIT_ACKED] = acked_q;
    ctrl_w = 8'h00;
    ctrl_w[BIT_STALL_REQ] = stall_req_q;
    ctrl_w[BIT_FIFO_ARMED] = armed_q;
    intr_w = 8'h00;
    intr_w[BIT_TX_INTR] = intr_q;
  end

  // axi write side: address and data captured separately, either order
  assign wr_fire = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid;
      s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready) &&
                      !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (hit(awaddr_q, OFF_STATUS) || hit(awaddr_q, OFF_CTRL) ||
                      hit(awaddr_q, OFF_INTR)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read side: one cycle turnaround, arready low while a read is held
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (hit(s_axi_araddr, OFF_STATUS)) begin
        s_axi_rdata <= {24'h000000, status_w};
      end else if (hit(s_axi_araddr, OFF_CTRL)) begin
        s_axi_rdata <= {24'h000000, ctrl_w};
      end else if (hit(s_axi_araddr, OFF_INTR)) begin
        s_axi_rdata <= {24'h000000, intr_w};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : cis_ctl_in_status

// File: rtl/cis_pkg.sv
package cis_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_INTR = 4'h8;
  localparam int BIT_TOGGLE = 7;
  localparam int BIT_STAGE = 4;
  localparam int BIT_STALLED = 3;
  localparam int BIT_NAKED = 2;
  localparam int BIT_ERROR = 1;
  localparam int BIT_ACKED = 0;
  localparam int BIT_STALL_REQ = 3;
  localparam int BIT_FIFO_ARMED = 1;
  localparam int BIT_TX_INTR = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    HS_NONE,
    HS_STALL,
    HS_NAK,
    HS_DATA
  } cis_hs_t;
  typedef struct packed {
    logic in_token;
    logic setup_begin;
    logic setup_done;
    logic status_stage;
    logic tx_done;
    logic host_ack;
    logic tx_error;
  } cis_link_ev_t;
  typedef struct packed {
    logic [3:0] endp;
    logic token_crc_ok;
  } cis_token_t;
endpackage : cis_pkg

// File: test/cis_ctl_in_status_bench.sv
`timescale 1ns/1ns
module cis_ctl_in_status_bench;
  import cis_pkg::*;
  logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic arm_set, pid, irq, busy, pid_seen;
  logic [3:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp, wresp;
  logic [2:0] cmd;
  cis_link_ev_t ev;
  cis_token_t tok;
  cis_hs_t hs, hs_seen;
  bit tg, sg, st, nk, er, ak, arm, stl, it;
  int miscompares, compares, cyc, tn;
  cis_ctl_in_status dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .link_ev(ev), .token(tok),
    .fifo_arm_set(arm_set), .hs_answer(hs), .data_pid_one(pid),
    .tx_intr(irq));
  cis_host host_u (.aclk(aclk), .cmd(cmd), .busy(busy), .link_ev(ev),
    .token(tok));
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // answer seen during the last transaction, cleared as a new one starts
  always @(posedge aclk) begin
    if (cmd != 3'h0) hs_seen <= HS_NONE;
    else if (hs !== HS_NONE) begin
      hs_seen <= hs;
      pid_seen <= pid;
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task axw(input logic [3:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (bv !== 1'h1);
    wresp = bresp;
    br <= 1'h0;
  endtask : axw
  task axr(input logic [3:0] a);
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
    end while (rv !== 1'h1);
    // rready stays up: back-to-back reads never drop and raise it at once
  endtask : axr
  task vfy;
    axr(OFF_STATUS);
    chk(rd, {tg, 2'h0, sg, st, nk, er, ak});
    axr(OFF_CTRL);
    chk(rd, {stl, 1'h0, arm, 1'h0});
    axr(OFF_INTR);
    chk(rd, it);
    chk(irq, it);
    tn++;
    $display("test step %0d done", tn);
  endtask : vfy
  task arm_fifo;
    arm_set <= 1'h1;
    @(posedge aclk);
    arm_set <= 1'h0;
    arm = 1'h1;
  endtask : arm_fifo
  task run(input logic [2:0] op);
    cis_hs_t eh;
    eh = stl ? HS_STALL : arm ? HS_DATA : HS_NAK;
    cmd <= op;
    @(posedge aclk);
    cmd <= 3'h0;
    do @(posedge aclk); while (busy !== 1'h0);
    repeat (2) @(posedge aclk);
    if (op < 3'h5) chk(hs_seen, op == 3'h4 ? HS_NONE : eh);
    if (op == 3'h3) begin
      {st, nk, er} = 3'h1;
    end else if (op == 3'h1 || op == 3'h2) begin
      st = eh == HS_STALL;
      nk = eh == HS_NAK;
      er = eh == HS_DATA && op == 3'h2;
    end
    if (op == 3'h1 && eh == HS_DATA) begin
      chk(pid_seen, tg);
      {ak, it, arm} = 3'h6;
      tg = !tg;
    end
    if (op == 3'h5) {sg, ak, tg, stl, arm} = 5'h4;
    if (op == 3'h6) sg = 1'h1;
  endtask : run
  initial begin
    {aresetn, awv, wv, br, arv, rr, arm_set, pid_seen} = '0;
    {awa, ara, wd, cmd, cyc, tn, miscompares, compares} = '0;
    hs_seen = HS_NONE;
    void'($urandom(33));
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    vfy();
    axr(4'hC);
    chk(rresp, RESP_SLVERR);
    chk(rd, 32'h0);
    axw(4'hC, 32'hFF);
    chk(wresp, RESP_SLVERR);
    run(3'h2);
    vfy();
    axw(OFF_CTRL, 32'h8);
    stl = 1'h1;
    run(3'h2);
    vfy();
    run(3'h5);
    vfy();
    arm_fifo();
    run(3'h1);
    vfy();
    // read-only bits ignore the write, only acked and the interrupt bit clear
    axw(OFF_STATUS, 32'hFF);
    {ak, it} = 2'h0;
    vfy();
    run(3'h6);
    arm_fifo();
    run(3'h1);
    vfy();
    run(3'h5);
    axw(OFF_INTR, 32'h1);
    it = 1'h0;
    vfy();
    // host never acks a no-data answer, so only unacked runs or token errors then
    repeat (16) begin
      if ($urandom % 2) arm_fifo();
      run(arm ? 3'(1 + $urandom % 3) : ($urandom % 2 ? 3'h2 : 3'h4));
      if ($urandom % 2) begin
        axw(OFF_STATUS, 32'h1);
        {ak, it} = 2'h0;
      end
      vfy();
    end
    end_sim();
  end
endmodule : cis_ctl_in_status_bench

// File: test/cis_host.sv
`timescale 1ns/1ns
module cis_host
  import cis_pkg::*;
(
  input wire logic aclk,
  input wire logic [2:0] cmd,
  output logic busy,
  output cis_pkg::cis_link_ev_t link_ev,
  output cis_pkg::cis_token_t token
);
  logic [2:0] op_q = 3'h0;
  logic [1:0] ph_q = 2'h0;
  logic [4:0] rnd_q = 5'h0;
  assign busy = ph_q != 2'h0;
  // pulses built in a local copy so each output is written once per edge
  always @(posedge aclk) begin : step
    cis_link_ev_t ev_d;
    ev_d = '0;
    rnd_q <= rnd_q + 5'h7;
    if (ph_q == 2'h0 && cmd != 3'h0) begin
      op_q <= cmd;
      ph_q <= (cmd == 3'h6) ? 2'h0 : 2'h1;
      ev_d.in_token = cmd < 3'h5;
      ev_d.setup_begin = cmd == 3'h5;
      ev_d.status_stage = cmd == 3'h6;
    end else if (ph_q == 2'h1) begin
      ph_q <= 2'h2;
    end else if (ph_q == 2'h2) begin
      ph_q <= 2'h0;
      ev_d.tx_done = op_q == 3'h1 || op_q == 3'h2;
      ev_d.host_ack = op_q == 3'h1;
      ev_d.tx_error = op_q == 3'h3;
      ev_d.setup_done = op_q == 3'h5;
    end
    link_ev <= ev_d;
    // idle token lines wander, never hold the last value
    token <= ev_d.in_token ? {4'h0, cmd != 3'h4} : rnd_q;
  end
endmodule : cis_host

// File: test/cis_monitor.sv
`timescale 1ns/1ns
module cis_monitor
  import cis_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cis_pkg::cis_link_ev_t link_ev,
  input wire cis_pkg::cis_token_t token,
  input wire cis_pkg::cis_hs_t hs_answer,
  input wire logic data_pid_one,
  input wire logic tx_intr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic vtok;
  logic acked;
  assign vtok = link_ev.in_token && token.token_crc_ok && token.endp == 4'h0;
  assign acked = hs_answer == HS_DATA && link_ev.tx_done && link_ev.host_ack;
  AST_VALID_TOKEN: assert property (vtok |=> hs_answer != HS_NONE)
    else $error("valid in token unanswered");
  AST_BAD_TOKEN: assert property (link_ev.in_token && !token.token_crc_ok
    && hs_answer == HS_NONE |=> hs_answer == HS_NONE)
    else $error("bad token answered");
  AST_ANSWER_HELD: assert property (hs_answer != HS_NONE &&
    !link_ev.tx_done && !link_ev.tx_error |=> $stable(hs_answer))
    else $error("answer changed early");
  AST_ANSWER_ENDS: assert property (hs_answer != HS_NONE &&
    (link_ev.tx_done || link_ev.tx_error) |=> hs_answer == HS_NONE)
    else $error("answer not ended");
  AST_ACK_INTR: assert property (acked |-> ##2 tx_intr)
    else $error("no interrupt after ack");
  AST_TOGGLE_FLIP: assert property (acked && !link_ev.setup_done |->
    ##2 data_pid_one != $past(data_pid_one, 2))
    else $error("toggle not inverted");
  AST_SETUP_TOGGLE: assert property (link_ev.setup_done |-> ##2 data_pid_one)
    else $error("toggle not set by setup");
  AST_INTR_CAUSE: assert property ($rose(tx_intr) |-> $past(acked, 2))
    else $error("interrupt without ack");
  cover property (acked);
  cover property (hs_answer == HS_STALL);
  cover property (link_ev.setup_done);
endmodule : cis_monitor
bind cis_ctl_in_status cis_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
  .link_ev(link_ev), .token(token), .hs_answer(hs_answer),
  .data_pid_one(data_pid_one), .tx_intr(tx_intr));
